//--- sim/data_memory_model.sv
// Memory partner answering reads promptly or slowly
`timescale 1ns/1ns
module data_memory_model (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        slow,
  input  wire        mem_rd_r,
  input  wire [15:0] mem_addr_r,
  output reg         mem_ack,
  output reg  [15:0] mem_rdata
);
  reg [1:0] wait_r;
  // Data valid only with ack; otherwise it toggles so stale reads show
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      wait_r    <= 2'h0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd_r && !mem_ack) begin
        if (wait_r == (slow ? 2'h2 : 2'h0)) begin
          mem_ack   <= 1'b1;
          wait_r    <= 2'h0;
          mem_rdata <= {~mem_addr_r[7:0], mem_addr_r[15:8] ^ 8'h96};
        end else
          wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // data_memory_model

//--- sim/operand_address_generator_monitor.sv
// Port checker for the operand address generator
`timescale 1ns/1ns
`include "oag_defs.vh"
module oag_monitor #(
  parameter ADDR_W = 16
) (
  input wire        core_clk,
  input wire        rst_n,
  input wire [3:0]  mode,
  input wire [3:0]  op_class,
  input wire [15:0] reg_value,
  input wire        mem_ack,
  input wire        mem_rd_r,
  input wire [15:0] mem_addr_r,
  input wire [15:0] ea_r,
  input wire [2:0]  bit_num_r,
  input wire [7:0]  bit_mask_r,
  input wire [15:0] reg_new_r,
  input wire        reg_we_r,
  input wire [15:0] branch_r,
  input wire        branch_valid_r,
  input wire        illegal_r,
  input wire        done_r
);
  // ----
  // Checks; bench holds decode inputs until done
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  branch_even_a: assert property (branch_valid_r |-> !branch_r[0])
    else $error("odd branch target");
  word_even_a: assert property (mem_rd_r && op_class == `OP_WORD_MOVE |-> !mem_addr_r[0])
    else $error("odd word address");
  postinc_step_a: assert property (reg_we_r && mode == `AM_POSTINC |->
    reg_new_r == ea_r + ((op_class == `OP_WORD_MOVE) ? 16'h0002 : 16'h0001))
    else $error("bad post step");
  predec_step_a: assert property (reg_we_r && mode == `AM_PREDEC |-> ea_r == reg_new_r &&
    reg_new_r == reg_value - ((op_class == `OP_WORD_MOVE) ? 16'h0002 : 16'h0001))
    else $error("bad pre step");
  short_page_a: assert property (done_r && mode == `AM_ABS8 && !illegal_r |->
    ea_r[15:8] == 8'hff) else $error("short page wrong");
  indirect_page_a: assert property (mem_rd_r && mode == `AM_MEMIND |->
    mem_addr_r[15:8] == 8'h00) else $error("pointer outside page");
  refuse_quiet_a: assert property ($rose(illegal_r) |->
    !reg_we_r && !branch_valid_r && !mem_rd_r) else $error("refused op acted");
  bit_mask_a: assert property (done_r && op_class == `OP_BIT |->
    bit_mask_r == (8'h01 << bit_num_r)) else $error("bad bit mask");
  ack_done_a: assert property (mem_rd_r && mem_ack |=> !mem_rd_r ##1 done_r)
    else $error("read end wrong");
endmodule // oag_monitor
bind operand_address_generator oag_monitor #(.ADDR_W(ADDR_W)) mon (
  .core_clk(core_clk), .rst_n(rst_n), .mode(mode), .op_class(op_class),
  .reg_value(reg_value), .mem_ack(mem_ack), .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r),
  .ea_r(ea_r), .bit_num_r(bit_num_r), .bit_mask_r(bit_mask_r), .reg_new_r(reg_new_r),
  .reg_we_r(reg_we_r), .branch_r(branch_r), .branch_valid_r(branch_valid_r),
  .illegal_r(illegal_r), .done_r(done_r));

//--- sim/tb_operand_address_generator.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ns
`include "oag_defs.vh"
module tb_operand_address_generator;
  reg core_clk = 0, rst_n = 0, start = 0, reg_low_half = 0, bit_from_byte4 = 0;
  reg const_two = 0, slow = 0;
  reg [3:0] mode = 4'h0, op_class = 4'h0;
  reg [15:0] reg_value = 16'h0000, word2 = 16'h0000, pc = 16'h0000;
  reg [7:0] byte2 = 8'h00, byte4 = 8'h00;
  wire mem_ack, mem_rd_r, word_op_r, reg_we_r, branch_valid_r, vector_overlap_r;
  wire bcd_ok_r, illegal_r, done_r;
  wire [15:0] mem_rdata, mem_addr_r, ea_r, operand_r, reg_new_r, branch_r;
  wire [2:0] bit_num_r;
  wire [7:0] bit_mask_r;
  integer miscompares = 0, compares = 0, it, n, k;
  reg [15:0] rv, w2, pcv, a;
  reg [7:0] b2, b4;
  reg lowh, bsel, c2, we_seen, br_seen;
  always #25 core_clk = ~core_clk;
  operand_address_generator DUT (.core_clk(core_clk), .rst_n(rst_n), .start(start),
    .mode(mode), .op_class(op_class), .reg_low_half(reg_low_half), .reg_value(reg_value),
    .byte2(byte2), .byte4(byte4), .word2(word2), .bit_from_byte4(bit_from_byte4),
    .const_two(const_two), .pc(pc), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .ea_r(ea_r), .operand_r(operand_r),
    .word_op_r(word_op_r), .bit_num_r(bit_num_r), .bit_mask_r(bit_mask_r),
    .reg_new_r(reg_new_r), .reg_we_r(reg_we_r), .branch_r(branch_r),
    .branch_valid_r(branch_valid_r), .vector_overlap_r(vector_overlap_r),
    .bcd_ok_r(bcd_ok_r), .illegal_r(illegal_r), .done_r(done_r));
  data_memory_model mem (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
    .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ----
  // Tasks
  // ----
  task check(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (miscompares == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Expected memory word, written apart from the model
  function [15:0] mw(input [15:0] x);
    mw = {~x[7:0], x[15:8] ^ 8'h96};
  endfunction
  // One decode, held until done; pulses are caught as they pass
  task run(input [3:0] m, input [3:0] o);
    begin
      @(posedge core_clk);
      mode <= m; op_class <= o; reg_value <= rv; byte2 <= b2; byte4 <= b4; word2 <= w2;
      pc <= pcv; reg_low_half <= lowh; bit_from_byte4 <= bsel; const_two <= c2; start <= 1;
      @(posedge core_clk);
      start <= 0;
      we_seen = 0;
      br_seen = 0;
      #1;
      for (n = 0; n < 40 && done_r !== 1'b1; n = n + 1) begin
        if (reg_we_r === 1'b1) we_seen = 1;
        if (branch_valid_r === 1'b1) br_seen = 1;
        @(posedge core_clk);
        #1;
      end
      if (n == 40) begin
        miscompares = miscompares + 1;
        test_done;
      end
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    k = $urandom(25471);
    repeat (6) @(posedge core_clk);
    rst_n <= 1;
    for (it = 0; it < 68; it = it + 1) begin
      k = it % 17;
      rv = $urandom; w2 = $urandom; pcv = $urandom; b2 = $urandom; b4 = $urandom;
      {lowh, bsel, c2} = $urandom;
      slow <= $urandom;
      if (k == 3 || k == 5) rv[0] = 1'b0;
      if (it < 17) begin
        if (k == 4) rv = 16'h0000; // Wrap corner
        if (k == 9) b2 = 8'h80; // Furthest back
        if (k == 10) b2 = 8'h3d; // Last vector byte
      end
      case (k)
        0: begin run(`AM_IND, `OP_BYTE_MOVE); check(ea_r, rv);
          check(mem_addr_r, rv);
          check(operand_r & 16'h00ff, mw(rv) & 16'h00ff); end
        1: begin run(`AM_DISP, `OP_WORD_MOVE); a = (rv + w2) & 16'hfffe;
          check(ea_r, a); check(operand_r, mw(a)); end
        2: begin run(`AM_POSTINC, `OP_BYTE_MOVE); check(ea_r, rv);
          check(reg_new_r, rv + 16'h0001); check(we_seen, 1'b1); end
        3: begin run(`AM_POSTINC, `OP_WORD_MOVE); check(reg_new_r, rv + 16'h0002);
          check(operand_r, mw(rv)); end
        4: begin run(`AM_PREDEC, `OP_BYTE_MOVE); check(ea_r, rv - 16'h0001); end
        5: begin run(`AM_PREDEC, `OP_WORD_MOVE); check(reg_new_r, rv - 16'h0002);
          check(ea_r, rv - 16'h0002); check(we_seen, 1'b1); end
        6: begin run(`AM_ABS8, `OP_BYTE_MOVE); check(ea_r, {8'hff, b2}); end
        7: begin run(`AM_IMM, `OP_WORD_MOVE); check(operand_r, w2); end
        8: begin run(`AM_IMM, `OP_BYTE_ALU); check(operand_r & 16'h00ff, {8'h00, b2}); end
        9: begin run(`AM_PCREL, `OP_BRANCH); check(br_seen, 1'b1);
          check(branch_r, ({pcv[15:1], 1'b0} + {{8{b2[7]}}, b2}) & 16'hfffe); end
        10: begin run(`AM_MEMIND, `OP_JUMP); check(vector_overlap_r, b2 <= 8'h3d);
          check(branch_r, mw({8'h00, b2} & 16'hfffe) & 16'hfffe); end
        11: begin run(`AM_ABS16, `OP_BYTE_ALU); check(illegal_r, 1'b1);
          check(we_seen | br_seen, 1'b0); end
        12: begin run(`AM_REG, `OP_BIT); a = bsel ? b4 : b2; check(bit_num_r, a[6:4]);
          check(bit_mask_r, 8'h01 << a[6:4]); end
        13: begin run(`AM_REG, `OP_SMALL_CONST); check(operand_r, c2 ? 16'h2 : 16'h1); end
        14: begin run(`AM_REG, `OP_WORD_ALU); check(operand_r, rv);
          check(word_op_r, 1'b1); end
        15: begin run(`AM_ABS16, `OP_JUMP); check(branch_r, w2 & 16'hfffe); end
        default: begin run(`AM_REG, `OP_DECIMAL); a = lowh ? rv : rv >> 8;
          check(operand_r, a & 16'h00ff);
          check(bcd_ok_r, a[7:4] < 4'ha && a[3:0] < 4'ha); end
      endcase
    end
    test_done;
  end
endmodule // tb_operand_address_generator

//--- src/bcd_nibble_check.v
// Packed BCD nibble validity check
`timescale 1ns/1ns
module bcd_nibble_check (
  input  wire [7:0] data,
  output wire       hi_ok,
  output wire       lo_ok
);
  // Each nibble is one decimal digit
  assign hi_ok = (data[7:4] < 4'ha);
  assign lo_ok = (data[3:0] < 4'ha);
endmodule // bcd_nibble_check

//--- src/branch_target.v
// PC-relative branch target adder
`timescale 1ns/1ns
module branch_target (
  input  wire [15:0] pc,
  input  wire [7:0]  disp,
  output wire [15:0] target
);
  // Sign-extend and add from the even fetch address, wrapping at 64K
  wire [15:0] sum;
  assign sum    = {pc[15:1], 1'b0} + {{8{disp[7]}}, disp};
  assign target = {sum[15:1], 1'b0};
endmodule // branch_target

//--- src/oag_defs.vh
// Constants for the operand and branch address generator
`ifndef OAG_DEFS_VH
`define OAG_DEFS_VH
// ---------------------------------------------------------------
// Addressing modes (binary select codes from the decoder)
// ---------------------------------------------------------------
`define AM_REG      4'h0
`define AM_IND      4'h1
`define AM_DISP     4'h2
`define AM_POSTINC  4'h3
`define AM_PREDEC   4'h4
`define AM_ABS8     4'h5
`define AM_ABS16    4'h6
`define AM_IMM      4'h7
`define AM_PCREL    4'h8
`define AM_MEMIND   4'h9
// ---------------------------------------------------------------
// Operation classes
// ---------------------------------------------------------------
`define OP_BYTE_MOVE   4'h0
`define OP_WORD_MOVE   4'h1
`define OP_WORD_ALU    4'h2
`define OP_SMALL_CONST 4'h3
`define OP_MULTIPLY    4'h4
`define OP_DIVIDE      4'h5
`define OP_JUMP        4'h6
`define OP_BRANCH      4'h7
`define OP_BIT         4'h8
`define OP_BYTE_ALU    4'h9
`define OP_DECIMAL     4'ha
// ---------------------------------------------------------------
// Address constants
// ---------------------------------------------------------------
`define SHORT_ABS_PAGE 8'hff
`define ZERO_PAGE      8'h00
`define VECTOR_LAST    16'h003d
`define STEP_BYTE      16'h0001
`define STEP_WORD      16'h0002
`define BIT_FIELD_LSB  4
`endif

//--- src/operand_address_generator.v
// Operand and branch address generation for the core
`timescale 1ns/1ns
`include "oag_defs.vh"
module operand_address_generator #(
  parameter ADDR_W = 16
) (
  input  wire              core_clk,
  input  wire              rst_n,
  input  wire              start,
  input  wire [3:0]        mode,
  input  wire [3:0]        op_class,
  input  wire              reg_low_half,
  input  wire [15:0]       reg_value,
  input  wire [7:0]        byte2,
  input  wire [7:0]        byte4,
  input  wire [15:0]       word2,
  input  wire              bit_from_byte4,
  input  wire              const_two,
  input  wire [15:0]       pc,
  input  wire              mem_ack,
  input  wire [15:0]       mem_rdata,
  output reg               mem_rd_r,
  output reg  [15:0]       mem_addr_r,
  output reg  [15:0]       ea_r,
  output reg  [15:0]       operand_r,
  output reg               word_op_r,
  output reg  [2:0]        bit_num_r,
  output reg  [7:0]        bit_mask_r,
  output reg  [15:0]       reg_new_r,
  output reg               reg_we_r,
  output reg  [15:0]       branch_r,
  output reg               branch_valid_r,
  output reg               vector_overlap_r,
  output reg               bcd_ok_r,
  output reg               illegal_r,
  output reg               done_r
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Word accesses drop bit zero
  function [15:0] align;
    input [15:0] a;
    input        w;
    begin
      align = w ? {a[15:1], 1'b0} : a;
    end
  endfunction

  // Size of pointer step: 1 byte or 2 for word moves
  function [15:0] step;
    input w;
    begin
      step = w ? `STEP_WORD : `STEP_BYTE;
    end
  endfunction

  // Byte operand from the chosen half of the register
  function [7:0] byte_half;
    input [15:0] r;
    input        low;
    begin
      byte_half = low ? r[7:0] : r[15:8];
    end
  endfunction

  // Read data fitted to the access width
  function [15:0] read_fit;
    input [15:0] d;
    input        w;
    begin
      read_fit = w ? d : {8'h00, d[7:0]};
    end
  endfunction

  // Classes that carry word operands
  function word_class;
    input [3:0] op;
    begin
      word_class = (op == `OP_WORD_MOVE) || (op == `OP_WORD_ALU) ||
                   (op == `OP_SMALL_CONST) || (op == `OP_MULTIPLY) ||
                   (op == `OP_DIVIDE);
    end
  endfunction

  // ---------------------------------------------------------------
  // Decode of operation width and legality
  // ---------------------------------------------------------------
  reg        is_word;
  reg        legal;
  wire       is_move = (op_class == `OP_BYTE_MOVE) || (op_class == `OP_WORD_MOVE);
  wire       is_jump = (op_class == `OP_JUMP);
  always @* begin
    is_word = word_class(op_class);
    legal = 1'b1;
    if (mode == `AM_DISP) begin
      legal = is_move;
    end else if (mode == `AM_POSTINC || mode == `AM_PREDEC) begin
      legal = is_move;
    end else if (mode == `AM_ABS8) begin
      legal = (op_class == `OP_BYTE_MOVE);
    end else if (mode == `AM_ABS16) begin
      legal = is_move || is_jump;
    end else if (mode == `AM_IMM) begin
      legal = !(op_class == `OP_SMALL_CONST);
    end else if (mode == `AM_PCREL) begin
      legal = (op_class == `OP_BRANCH);
    end else if (mode == `AM_MEMIND) begin
      legal = is_jump;
    end
  end

  // ---------------------------------------------------------------
  // Address and operand computation
  // ---------------------------------------------------------------
  // Results of the two small helper units
  wire [15:0] pcrel_target;
  wire        bcd_hi_ok;
  wire        bcd_lo_ok;

  branch_target u_branch (
    .pc     (pc),
    .disp   (byte2),
    .target (pcrel_target)
  );

  bcd_nibble_check u_bcd (
    .data  (byte_half(reg_value, reg_low_half)),
    .hi_ok (bcd_hi_ok),
    .lo_ok (bcd_lo_ok)
  );

  // Combinational results of the decode
  reg [15:0] ea_nxt;
  reg [15:0] opnd_nxt;
  reg [15:0] regn_nxt;
  reg        regwe_nxt;
  reg        need_rd;
  reg        word_acc;
  wire [2:0] bitn = bit_from_byte4 ? byte4[`BIT_FIELD_LSB+2:`BIT_FIELD_LSB]
                                   : byte2[`BIT_FIELD_LSB+2:`BIT_FIELD_LSB];

  // Effective address, pointer update and whether memory must be read
  always @* begin
    ea_nxt    = 16'h0000;
    regn_nxt  = reg_value;
    regwe_nxt = 1'b0;
    need_rd   = 1'b0;
    word_acc  = (op_class == `OP_WORD_MOVE);
    case (mode)
      // Pointer register is the address
      `AM_IND: begin
        ea_nxt  = reg_value;
        need_rd = 1'b1;
      end
      // Pointer plus the second instruction word
      `AM_DISP: begin
        ea_nxt  = reg_value + word2;
        need_rd = 1'b1;
      end
      // Read at the pointer, then step it
      `AM_POSTINC: begin
        ea_nxt    = reg_value;
        regn_nxt  = reg_value + step(word_acc);
        regwe_nxt = 1'b1;
        need_rd   = 1'b1;
      end
      // Step first; no read is made in this mode, load or store
      `AM_PREDEC: begin
        regn_nxt  = reg_value - step(word_acc);
        ea_nxt    = regn_nxt;
        regwe_nxt = 1'b1;
      end
      // Short form lives in the top page
      `AM_ABS8: begin
        ea_nxt  = {`SHORT_ABS_PAGE, byte2};
        need_rd = 1'b1;
      end
      // Jumps take the word as target without a read
      `AM_ABS16: begin
        ea_nxt  = word2;
        need_rd = !is_jump;
      end
      // Target from the branch adder
      `AM_PCREL: begin
        ea_nxt = pcrel_target;
      end
      // Pointer word fetched from the bottom page
      `AM_MEMIND: begin
        ea_nxt   = {`ZERO_PAGE, byte2};
        word_acc = 1'b1;
        need_rd  = 1'b1;
      end
      default: begin
        ea_nxt = 16'h0000;
      end
    endcase
    // Jumps always go to word boundaries
    if (is_jump || word_acc)
      ea_nxt = align(ea_nxt, 1'b1);
  end

  // ---------------------------------------------------------------
  // Operand for register and immediate forms
  // ---------------------------------------------------------------
  // Memory forms leave this at zero; read data replaces it later, except where no read is made or the read fetches a memory-indirect pointer
  always @* begin
    opnd_nxt = 16'h0000;
    case (mode)
      `AM_REG: begin
        if (op_class == `OP_SMALL_CONST)
          opnd_nxt = step(const_two);
        else if (is_word)
          opnd_nxt = reg_value;
        else
          opnd_nxt = {8'h00, byte_half(reg_value, reg_low_half)};
      end
      `AM_IMM: begin
        opnd_nxt = (op_class == `OP_WORD_MOVE) ? word2 : {8'h00, byte2};
      end
      default: begin
        opnd_nxt = 16'h0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Control sequencer
  // ---------------------------------------------------------------
  reg [2:0] state_r;
  reg       memind_r;
  // A decode is taken only in idle; a read ends on its acknowledge
  wire      take   = start && (state_r == ST_IDLE);
  wire      rd_end = mem_ack && (state_r == ST_WAIT);

  // Refused or read-free decodes still pass through DONE for one cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start && need_rd && legal)
            state_r <= ST_WAIT;
          else if (start)
            state_r <= ST_DONE;
        end
        ST_WAIT: begin
          if (mem_ack)
            state_r <= ST_DONE;
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Memory read request
  // ---------------------------------------------------------------
  // Request and address stand unchanged until the acknowledge edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_r   <= 1'b0;
      mem_addr_r <= 16'h0000;
      memind_r   <= 1'b0;
    end else if (take) begin
      mem_rd_r   <= need_rd && legal;
      memind_r   <= (mode == `AM_MEMIND);
      if (need_rd && legal)
        mem_addr_r <= ea_nxt;
    end else if (rd_end) begin
      mem_rd_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Decode results
  // ---------------------------------------------------------------
  // Captured at the take edge and held until the next one; operand_r is also replaced by the read data on the acknowledge of a read that is not memory-indirect
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_r             <= 16'h0000;
      operand_r        <= 16'h0000;
      word_op_r        <= 1'b0;
      bit_num_r        <= 3'h0;
      bit_mask_r       <= 8'h00;
      reg_new_r        <= 16'h0000;
      vector_overlap_r <= 1'b0;
      bcd_ok_r         <= 1'b0;
      illegal_r        <= 1'b0;
    end else if (take) begin
      illegal_r        <= !legal;
      ea_r             <= ea_nxt;
      operand_r        <= opnd_nxt;
      word_op_r        <= word_acc || is_word;
      bit_num_r        <= bitn;
      bit_mask_r       <= 8'h01 << bitn;
      bcd_ok_r         <= (op_class == `OP_DECIMAL) && bcd_hi_ok && bcd_lo_ok;
      vector_overlap_r <= (mode == `AM_MEMIND) && ({8'h00, byte2} <= `VECTOR_LAST);
      reg_new_r        <= regn_nxt;
    end else if (rd_end && !memind_r) begin
      // Byte reads use the low lane only
      operand_r <= read_fit(mem_rdata, word_op_r);
    end
  end

  // ---------------------------------------------------------------
  // Branch target and one-cycle pulses
  // ---------------------------------------------------------------
  // Refused decodes raise no write or branch pulse and start no read; done_r still pulses
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      branch_r       <= 16'h0000;
      branch_valid_r <= 1'b0;
      reg_we_r       <= 1'b0;
      done_r         <= 1'b0;
    end else begin
      done_r         <= (state_r == ST_DONE);
      reg_we_r       <= take && regwe_nxt && legal;
      branch_valid_r <= 1'b0;
      if (take && !(need_rd && legal)) begin
        branch_r       <= ea_nxt;
        branch_valid_r <= legal && (is_jump || op_class == `OP_BRANCH);
      end else if (rd_end && memind_r) begin
        branch_r       <= align(mem_rdata, 1'b1);
        branch_valid_r <= 1'b1;
      end
    end
  end
endmodule // operand_address_generator
